// ==== design/anc_audio_pkg.sv ====
// shared types and constants of the ancillary data and embedded audio validator
package anc_audio_pkg;

    // error type indices, one sticky flag and one counter each
    localparam int ERR_HDR_FLAG    = 0;
    localparam int ERR_HDR_SAFETY  = 1;
    localparam int ERR_HDR_PARITY  = 2;
    localparam int ERR_BLOCK_ORDER = 3;
    localparam int ERR_DATA_WORD   = 4;
    localparam int ERR_CHECKSUM    = 5;
    localparam int ERR_CS_SAFETY   = 6;
    localparam int ERR_PLACEMENT   = 7;
    localparam int ERR_AUD_BROKEN  = 8;
    localparam int ERR_AUD_MISSING = 9;
    localparam int ERR_AUD_SPF     = 10;
    localparam int ERR_AUD_CADENCE = 11;
    localparam int ERR_AUD_PAIRING = 12;
    localparam int ERR_AUD_VALID   = 13;
    localparam int NUM_ERR         = 14;

    // word value classes
    localparam logic [9:0] WORD_ZERO      = 10'h000;
    localparam logic [9:0] WORD_ONES      = 10'h3ff;
    localparam logic [9:0] RELAX_ZERO_MAX = 10'h003;
    localparam logic [9:0] RELAX_ONES_MIN = 10'h3fc;

    // packet fields
    localparam logic [7:0] EDH_DID        = 8'hf4;
    localparam logic [7:0] AUDIO_DID_DEF  = 8'hff;
    localparam int         DID_TYPE1_BIT  = 7;
    localparam logic [7:0] DBN_MAX        = 8'hff;

    // audio sample word layout
    localparam int AUD_Z_BIT  = 0;
    localparam int AUD_CH_LSB = 1;
    localparam int AUD_V_BIT  = 5;

    // audio structure figures
    localparam logic [7:0]  BLOCK_LEN    = 8'hc0;
    localparam logic [11:0] SPF_525_LOW  = 12'h641;
    localparam logic [11:0] SPF_525_HIGH = 12'h642;
    localparam logic [11:0] SPF_625      = 12'h780;
    localparam logic [4:0]  CADENCE_SEQ  = 5'h15;

    localparam int FIFO_DEPTH = 8;
    localparam int CNT_WIDTH  = 16;

    // one word of the deserialised stream with its timing marks
    typedef struct packed {
        logic [9:0] data;        // 10-bit video word
        logic       eavEnd;      // last word of an end-of-active-video mark
        logic       frameStart;  // first word of a new frame
        logic       vanc;        // word lies in the active vertical interval
    } videoWord_t;

    typedef enum logic [2:0] {
        P_IDLE = 3'b000,
        P_PRE1 = 3'b001,
        P_PRE2 = 3'b010,
        P_DID  = 3'b011,
        P_SDID = 3'b100,
        P_DC   = 3'b101,
        P_UDW  = 3'b110,
        P_CS   = 3'b111
    } parseState_t;

endpackage

// ==== design/anc_data_audio_validator.sv ====
// word fifo and the ancillary data / embedded audio validator top
// Functional notes
// - preamble 000 3ff 3ff, relaxed near values accepted
// - strict mode flags inexact preamble words
// - header and checksum bit 9 inverts bit 8
// - header words carry even parity over bits 8..0
// - block numbers follow 0/1, 255/0/1, N+1/0 order
// - relaxed: payload 000-003 or 3fc-3ff is illegal
// - strict: payload exactly 000 or 3ff is illegal
// - nine-bit sum from DID must equal checksum
// - horizontal packets follow EAV or prior packet
// - Z-bit starts must be 192 samples apart
// - channel without any Z-bit is flagged missing
// - samples per frame 1601/1602 or 1920
// - 525 cadence 1602,1601,1602,1601,1602 checked
// - channels 1-2 and 3-4 adjacent, odd first
// - audio validity bit set is an error
// - clear zeroes counters and restarts halted monitor
`timescale 1ns/10ps

module word_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,      // word clock
    input  wire logic             rst_b,     // synchronous reset, active low
    input  wire logic             inValid,   // writer offers a word
    input  wire logic [WIDTH-1:0] inData,    // offered word
    output logic                  inReady,   // fifo can take a word
    output logic                  outValid,  // fifo holds a word
    output logic      [WIDTH-1:0] outData,   // oldest word
    input  wire logic             outReady   // reader takes the oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
        logic                        ready;
    } fifoState_t;

    fifoState_t s_reg;
    fifoState_t s_next;
    logic       push;
    logic       pop;

    assign inReady  = s_reg.ready;
    assign outValid = (s_reg.count != '0);
    assign outData  = s_reg.mem[s_reg.rd];

    always_comb begin
        s_next = s_reg;
        push   = inValid && s_reg.ready;
        pop    = outValid && outReady;
        if (push) begin
            s_next.mem[s_reg.wr] = inData;
            s_next.wr = (s_reg.wr == AW'(DEPTH - 1)) ? '0 : AW'(s_reg.wr + 1'b1);
        end
        if (pop) begin
            s_next.rd = (s_reg.rd == AW'(DEPTH - 1)) ? '0 : AW'(s_reg.rd + 1'b1);
        end
        if (push && !pop) begin
            s_next.count = (AW + 1)'(s_reg.count + 1'b1);
        end else if (pop && !push) begin
            s_next.count = (AW + 1)'(s_reg.count - 1'b1);
        end
        // ready is registered so the writer sees a flop
        s_next.ready = (s_next.count != (AW + 1)'(DEPTH));
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

module anc_data_audio_validator #(
    parameter logic [7:0] AUDIO_DID = anc_audio_pkg::AUDIO_DID_DEF,
    parameter int         CNT_W     = anc_audio_pkg::CNT_WIDTH,
    parameter int         DEPTH     = anc_audio_pkg::FIFO_DEPTH
) (
    input  wire logic                                   mclk,        // word clock
    input  wire logic                                   rst_b,       // sync reset, active low
    input  wire logic                                   wordValid,   // stream word present
    input  wire anc_audio_pkg::videoWord_t              wordIn,      // stream word and marks
    output logic                                        inReady,     // stream word accepted
    input  wire logic                                   strictMode,  // 1 strict, 0 relaxed
    input  wire logic                                   line625,     // 1 625-line, 0 525-line
    input  wire logic                                   haltOnError, // stop on any error
    input  wire logic                                   clearCmd,    // clear counters, restart
    output logic [anc_audio_pkg::NUM_ERR-1:0]           errFlags,    // sticky error flags
    output logic [anc_audio_pkg::NUM_ERR-1:0][CNT_W-1:0] errCounts,  // saturating counters
    output logic                                        halted       // monitoring stopped
);
    localparam int NE = anc_audio_pkg::NUM_ERR;

    typedef struct packed {
        anc_audio_pkg::parseState_t state;
        logic                       inexact;
        logic                       misplaced;
        logic                       atStart;
        logic [7:0]                 did;
        logic [8:0]                 sum;
        logic [7:0]                 left;
        logic [1:0]                 sub;
        logic                       dbnValid;
        logic [7:0]                 dbnDid;
        logic [7:0]                 dbn;
        logic [3:0][7:0]            blkCnt;
        logic [3:0]                 zSeen;
        logic [3:0]                 zFrame;
        logic [3:0]                 chSeen;
        logic                       pairOpen;
        logic [1:0]                 pairExpect;
        logic [11:0]                frameCnt;
        logic                       frameLive;
        logic [4:0]                 hist;
        logic [4:0]                 histOk;
        logic [NE-1:0]              flags;
        logic [NE-1:0][CNT_W-1:0]   cnts;
        logic                       halted;
    } valState_t;

    valState_t                 s_reg;
    valState_t                 s_next;
    logic                      fifoValid;
    logic [$bits(anc_audio_pkg::videoWord_t)-1:0] fifoData;
    anc_audio_pkg::videoWord_t fw;
    logic                      take;
    logic [9:0]                w;
    logic                      zeroRelax;
    logic                      onesRelax;
    logic                      zeroExact;
    logic                      onesExact;
    logic [1:0]                ch;
    logic [NE-1:0]             errEvent;

    word_fifo #(
        .WIDTH ($bits(anc_audio_pkg::videoWord_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .inValid  (wordValid),
        .inData   (wordIn),
        .inReady  (inReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (!s_reg.halted)
    );

    assign fw        = fifoData;
    assign errFlags  = s_reg.flags;
    assign errCounts = s_reg.cnts;
    assign halted    = s_reg.halted;

    // true when five per-frame bits are a rotation of the 525 cadence
    function automatic logic cadenceOk(input logic [4:0] h);
        logic       ok;
        logic [4:0] rot;
        ok  = 1'b0;
        rot = anc_audio_pkg::CADENCE_SEQ;
        for (int i = 0; i < 5; i++) begin
            if (h == rot) begin
                ok = 1'b1;
            end
            rot = {rot[3:0], rot[4]};
        end
        return ok;
    endfunction

    always_comb begin
        s_next    = s_reg;
        errEvent  = '0;
        take      = fifoValid && !s_reg.halted;
        w         = fw.data;
        zeroRelax = (w <= anc_audio_pkg::RELAX_ZERO_MAX);
        onesRelax = (w >= anc_audio_pkg::RELAX_ONES_MIN);
        zeroExact = (w == anc_audio_pkg::WORD_ZERO);
        onesExact = (w == anc_audio_pkg::WORD_ONES);
        ch        = w[anc_audio_pkg::AUD_CH_LSB +: 2];

        if (take && fw.frameStart) begin
            if (s_reg.frameLive) begin
                if (line625) begin
                    errEvent[anc_audio_pkg::ERR_AUD_SPF] =
                        (s_reg.frameCnt != anc_audio_pkg::SPF_625);
                end else begin
                    errEvent[anc_audio_pkg::ERR_AUD_SPF] =
                        (s_reg.frameCnt != anc_audio_pkg::SPF_525_LOW) &&
                        (s_reg.frameCnt != anc_audio_pkg::SPF_525_HIGH);
                    s_next.hist   = {s_reg.hist[3:0],
                                     s_reg.frameCnt == anc_audio_pkg::SPF_525_HIGH};
                    s_next.histOk = {s_reg.histOk[3:0], !errEvent[anc_audio_pkg::ERR_AUD_SPF]};
                    errEvent[anc_audio_pkg::ERR_AUD_CADENCE] =
                        (&s_next.histOk) && !cadenceOk(s_next.hist);
                end
                errEvent[anc_audio_pkg::ERR_AUD_MISSING] =
                    |(s_reg.chSeen & ~s_reg.zFrame);
            end
            s_next.frameLive = 1'b1;
            s_next.frameCnt  = '0;
            s_next.zFrame    = '0;
            s_next.chSeen    = '0;
        end

        if (take) begin
            case (s_reg.state)
                anc_audio_pkg::P_IDLE: begin
                    if (zeroRelax) begin
                        s_next.state     = anc_audio_pkg::P_PRE1;
                        s_next.inexact   = !zeroExact;
                        s_next.misplaced = !s_reg.atStart && !fw.vanc;
                    end
                end
                anc_audio_pkg::P_PRE1: begin
                    if (onesRelax) begin
                        s_next.state   = anc_audio_pkg::P_PRE2;
                        s_next.inexact = s_reg.inexact || !onesExact;
                    end else if (zeroRelax) begin
                        s_next.inexact   = !zeroExact;
                        s_next.misplaced = !fw.vanc;
                    end else begin
                        s_next.state = anc_audio_pkg::P_IDLE;
                    end
                end
                anc_audio_pkg::P_PRE2: begin
                    if (onesRelax) begin
                        s_next.state = anc_audio_pkg::P_DID;
                        errEvent[anc_audio_pkg::ERR_HDR_FLAG] =
                            strictMode && (s_reg.inexact || !onesExact);
                    end else if (zeroRelax) begin
                        s_next.state     = anc_audio_pkg::P_PRE1;
                        s_next.inexact   = !zeroExact;
                        s_next.misplaced = !fw.vanc;
                    end else begin
                        s_next.state = anc_audio_pkg::P_IDLE;
                    end
                end
                anc_audio_pkg::P_DID, anc_audio_pkg::P_SDID, anc_audio_pkg::P_DC: begin
                    errEvent[anc_audio_pkg::ERR_HDR_SAFETY] = (w[9] == w[8]);
                    errEvent[anc_audio_pkg::ERR_HDR_PARITY] = ^w[8:0];
                    s_next.sum = s_reg.sum + w[8:0];
                    if (s_reg.state == anc_audio_pkg::P_DID) begin
                        s_next.state = anc_audio_pkg::P_SDID;
                        s_next.did   = w[7:0];
                        s_next.sum   = w[8:0];
                        errEvent[anc_audio_pkg::ERR_PLACEMENT] =
                            s_reg.misplaced && (w[7:0] != anc_audio_pkg::EDH_DID);
                    end else if (s_reg.state == anc_audio_pkg::P_SDID) begin
                        s_next.state = anc_audio_pkg::P_DC;
                        if (s_reg.did[anc_audio_pkg::DID_TYPE1_BIT]) begin
                            if (s_reg.dbnValid && s_reg.dbnDid == s_reg.did) begin
                                if (s_reg.dbn == '0 || s_reg.dbn == anc_audio_pkg::DBN_MAX) begin
                                    errEvent[anc_audio_pkg::ERR_BLOCK_ORDER] =
                                        (w[7:0] > 8'h01);
                                end else begin
                                    errEvent[anc_audio_pkg::ERR_BLOCK_ORDER] =
                                        (w[7:0] != 8'(s_reg.dbn + 1'b1)) &&
                                        (w[7:0] != 8'h00);
                                end
                            end
                            s_next.dbnValid = 1'b1;
                            s_next.dbnDid   = s_reg.did;
                            s_next.dbn      = w[7:0];
                        end
                    end else begin
                        s_next.left  = w[7:0];
                        s_next.sub   = '0;
                        s_next.state = (w[7:0] == 8'h00) ? anc_audio_pkg::P_CS
                                                         : anc_audio_pkg::P_UDW;
                    end
                end
                anc_audio_pkg::P_UDW: begin
                    s_next.sum = s_reg.sum + w[8:0];
                    if (strictMode) begin
                        errEvent[anc_audio_pkg::ERR_DATA_WORD] = zeroExact || onesExact;
                    end else begin
                        errEvent[anc_audio_pkg::ERR_DATA_WORD] = zeroRelax || onesRelax;
                    end
                    s_next.left = 8'(s_reg.left - 1'b1);
                    if (s_reg.left == 8'h01) begin
                        s_next.state = anc_audio_pkg::P_CS;
                    end
                    if (s_reg.did == AUDIO_DID) begin
                        s_next.sub = (s_reg.sub == 2'h2) ? 2'h0 : 2'(s_reg.sub + 1'b1);
                        if (s_reg.sub == 2'h2) begin
                            errEvent[anc_audio_pkg::ERR_AUD_VALID] =
                                w[anc_audio_pkg::AUD_V_BIT];
                        end
                        if (s_reg.sub == 2'h0) begin
                            for (int c = 0; c < 4; c++) begin
                                if (ch == 2'(c)) begin
                                    s_next.chSeen[c] = 1'b1;
                                    if (w[anc_audio_pkg::AUD_Z_BIT]) begin
                                        if (s_reg.zSeen[c] &&
                                            s_reg.blkCnt[c] != anc_audio_pkg::BLOCK_LEN) begin
                                            errEvent[anc_audio_pkg::ERR_AUD_BROKEN] = 1'b1;
                                        end
                                        s_next.blkCnt[c] = 8'h01;
                                        s_next.zSeen[c]  = 1'b1;
                                        s_next.zFrame[c] = 1'b1;
                                    end else if (s_reg.blkCnt[c] != 8'hff) begin
                                        s_next.blkCnt[c] = 8'(s_reg.blkCnt[c] + 1'b1);
                                    end
                                end
                            end
                            if (ch == 2'h0 && s_next.frameCnt != 12'hfff) begin
                                s_next.frameCnt = 12'(s_next.frameCnt + 1'b1);
                            end
                            if (s_reg.pairOpen) begin
                                errEvent[anc_audio_pkg::ERR_AUD_PAIRING] =
                                    (ch != s_reg.pairExpect);
                                s_next.pairOpen = 1'b0;
                            end else if (ch[0]) begin
                                errEvent[anc_audio_pkg::ERR_AUD_PAIRING] = 1'b1;
                            end else begin
                                s_next.pairOpen   = 1'b1;
                                s_next.pairExpect = {ch[1], 1'b1};
                            end
                        end
                    end
                end
                anc_audio_pkg::P_CS: begin
                    errEvent[anc_audio_pkg::ERR_CS_SAFETY] = (w[9] == w[8]);
                    errEvent[anc_audio_pkg::ERR_CHECKSUM]  = (w[8:0] != s_reg.sum);
                    s_next.state = anc_audio_pkg::P_IDLE;
                end
                default: begin
                    s_next.state = anc_audio_pkg::P_IDLE;
                end
            endcase
            // a packet may start right after an EAV or right after a checksum
            s_next.atStart = fw.eavEnd || (s_reg.state == anc_audio_pkg::P_CS);
        end

        // an event in the clearing cycle survives the clear
        for (int i = 0; i < NE; i++) begin
            if (clearCmd) begin
                s_next.flags[i] = errEvent[i];
                s_next.cnts[i]  = errEvent[i] ? CNT_W'(1) : '0;
            end else if (errEvent[i]) begin
                s_next.flags[i] = 1'b1;
                if (s_reg.cnts[i] != '1) begin
                    s_next.cnts[i] = CNT_W'(s_reg.cnts[i] + 1'b1);
                end
            end
        end
        if (haltOnError && (|errEvent)) begin
            s_next.halted = 1'b1;
        end else if (clearCmd) begin
            s_next.halted = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// ==== verification/anc_validator_properties.sv ====
// port-level checks of the validator
`timescale 1ns/10ps
module anc_validator_properties #(
    parameter int CNT_W = 16
) (
    input wire logic                                    mclk,        // clock
    input wire logic                                    rst_b,       // reset
    input wire logic                                    inReady,     // ready
    input wire logic                                    haltOnError, // halt select
    input wire logic                                    clearCmd,    // clear
    input wire logic [anc_audio_pkg::NUM_ERR-1:0]            errFlags,  // flags
    input wire logic [anc_audio_pkg::NUM_ERR-1:0][CNT_W-1:0] errCounts, // counters
    input wire logic                                    halted       // halted
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ready_reset_a: assert property ($rose(rst_b) |=> inReady)
        else $error("fifo not ready after reset");
    halt_rise_a: assert property ($rose(halted) |-> $past(haltOnError) && errFlags != '0)
        else $error("halt without error");
    halt_clear_a: assert property (clearCmd && !haltOnError |=> !halted)
        else $error("halt survived clear");
    halt_hold_a: assert property (halted && !clearCmd |=> halted)
        else $error("halt dropped by itself");
    for (genvar i = 0; i < anc_audio_pkg::NUM_ERR; i++) begin : g_err
        count_clear_a: assert property (clearCmd |=> errCounts[i] <= 1)
            else $error("counter not cleared");
        count_flag_a: assert property ((errCounts[i] != '0) == errFlags[i])
            else $error("flag and counter disagree");
        count_step_a: assert property (!clearCmd |=> errCounts[i]-$past(errCounts[i])<=1)
            else $error("counter stepped wrongly");
        flag_sticky_a: assert property (!clearCmd && errFlags[i] |=> errFlags[i])
            else $error("flag not sticky");
    end
endmodule

bind anc_data_audio_validator anc_validator_properties #(.CNT_W(CNT_W)) i_anc_validator_properties (
    .mclk, .rst_b, .inReady, .haltOnError, .clearCmd, .errFlags, .errCounts, .halted);

// ==== verification/video_source.sv ====
// upstream source model: offers queued words, holds each until taken
`timescale 1ns/10ps
module video_source (
    input  wire logic                 mclk,      // word clock
    input  wire logic                 inReady,   // validator takes a word
    output logic                      wordValid, // word offered
    output anc_audio_pkg::videoWord_t wordIn     // offered word
);
    anc_audio_pkg::videoWord_t pending[$];
    logic                      taken;
    initial begin
        wordValid = 1'b0;
        wordIn    = '0;
        taken     = 1'b0;
    end
    always @(posedge mclk) begin
        taken = wordValid & inReady;
    end
    // idle data toggles so a stale word never looks fresh
    always @(negedge mclk) begin
        if (taken || !wordValid) begin
            if (pending.size() > 0) begin
                wordIn    = pending.pop_front();
                wordValid = 1'b1;
            end else begin
                wordIn.data = ~wordIn.data;
                wordValid   = 1'b0;
            end
        end
    end
endmodule

// ==== verification/anc_data_audio_validator_tb.sv ====
// self-checking bench of the ancillary data and audio validator
`timescale 1ns/10ps
module anc_data_audio_validator_tb;
    logic                                         mclk, rst_b, inReady, wordValid, halted;
    logic                                         strictMode, line625, haltOnError, clearCmd;
    anc_audio_pkg::videoWord_t                    wordIn;
    logic [anc_audio_pkg::NUM_ERR-1:0]            errFlags;
    logic [anc_audio_pkg::NUM_ERR-1:0][15:0]      errCounts;
    int                                           n_mismatch, comparisons;
    anc_data_audio_validator i_anc_data_audio_validator (.mclk, .rst_b, .wordValid, .wordIn,
        .inReady, .strictMode, .line625, .haltOnError, .clearCmd, .errFlags, .errCounts, .halted);
    video_source i_video_source (.mclk, .inReady, .wordValid, .wordIn);
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask
    function automatic logic [9:0] hdr(input logic [7:0] b);
        return {~(^b), ^b, b};
    endfunction
    task automatic put(input logic [9:0] d, input logic eav);
        i_video_source.pending.push_back({d, eav, 2'b00});
    endtask
    // one packet, then flags, counts and halt compared and cleared
    task automatic packet(input logic [7:0] did, input logic [7:0] dbn, input logic [9:0] udw[$],
        input logic [9:0] pre0, input logic [9:0] didX, input logic [9:0] csX,
        input logic eavFirst, input logic [13:0] expFlags);
        logic [9:0] w[$];
        logic [8:0] sum;
        int         n;
        sum = '0;
        put(10'h200, eavFirst);
        put(pre0, 1'b0);
        put(10'h3ff, 1'b0);
        put(10'h3ff, 1'b0);
        w = {hdr(did) ^ didX, hdr(dbn), hdr(8'(udw.size()))};
        w = {w, udw};
        foreach (w[k]) begin
            sum += w[k][8:0];
            put(w[k], 1'b0);
        end
        put({~sum[8], sum} ^ csX, 1'b0);
        for (n = 0; n < 200 && (i_video_source.pending.size() > 0 || wordValid); n++) begin
            @(negedge mclk);
        end
        repeat (6) @(negedge mclk);
        check(errFlags, expFlags);
        for (n = 0; n < 14; n++) begin
            check(errCounts[n], expFlags[n]);
        end
        check(halted, haltOnError && expFlags != '0);
        clearCmd = 1'b1;
        @(negedge mclk);
        clearCmd = 1'b0;
        check({|errCounts, errFlags, halted}, 16'h0);
    endtask
    task automatic t_preamble();
        packet(8'h45, 8'h01, '{10'h100}, 10'h001, 10'h0, 10'h0, 1'b1, 14'h0000);
        strictMode = 1'b1;
        packet(8'h45, 8'h01, '{10'h100}, 10'h001, 10'h0, 10'h0, 1'b1, 14'h0001);
        packet(8'h45, 8'h01, '{10'h3fc}, 10'h000, 10'h0, 10'h0, 1'b1, 14'h0000);
        packet(8'h45, 8'h01, '{10'h3ff}, 10'h000, 10'h0, 10'h0, 1'b1, 14'h0010);
        strictMode = 1'b0;
        packet(8'h45, 8'h01, '{10'h002}, 10'h000, 10'h0, 10'h0, 1'b1, 14'h0010);
        packet(8'h45, 8'h01, '{10'h3fc}, 10'h000, 10'h0, 10'h0, 1'b1, 14'h0010);
        $display("test preamble and ranges done");
    endtask
    task automatic t_words();
        packet(8'h45, 8'h01, '{10'h100}, 10'h000, 10'h300, 10'h0, 1'b1, 14'h0004);
        packet(8'h45, 8'h01, '{10'h100}, 10'h000, 10'h200, 10'h0, 1'b1, 14'h0002);
        packet(8'h45, 8'h01, '{10'h100}, 10'h000, 10'h0, 10'h001, 1'b1, 14'h0020);
        packet(8'h45, 8'h01, '{10'h100}, 10'h000, 10'h0, 10'h200, 1'b1, 14'h0040);
        packet(8'h45, 8'h01, '{10'h100}, 10'h000, 10'h0, 10'h0, 1'b0, 14'h0080);
        packet(8'hf4, 8'h01, '{10'h100}, 10'h000, 10'h0, 10'h0, 1'b0, 14'h0000);
        haltOnError = 1'b1;
        packet(8'h45, 8'h01, '{10'h100}, 10'h000, 10'h0, 10'h001, 1'b1, 14'h0020);
        haltOnError = 1'b0;
        $display("test header, checksum, placement and halt done");
    endtask
    task automatic t_blocks();
        logic [7:0] seq[7] = '{8'hfe, 8'hff, 8'h01, 8'h03, 8'h00, 8'h00, 8'h02};
        logic [6:0] bad = 7'b1001000;
        for (int i = 0; i < 7; i++) begin
            packet(8'h85, seq[i], '{10'h100}, 10'h0, 10'h0, 10'h0, 1'b1, {bad[i], 3'b000});
        end
        $display("test block numbers done");
    endtask
    task automatic t_audio();
        packet(8'hff, 8'h00, '{10'h104, 10'h100, 10'h100, 10'h106, 10'h100, 10'h100,
            10'h100, 10'h100, 10'h120, 10'h102, 10'h100, 10'h100}, 10'h0, 10'h0, 10'h0, 1'b1,
            14'h2000);
        packet(8'hff, 8'h00, '{10'h102, 10'h100, 10'h100}, 10'h0, 10'h0, 10'h0, 1'b1,
            14'h1000);
        $display("test audio done");
    endtask
    // three frames of a Z-marked channel-1 and an unmarked channel-2 sample each; the first two are judged, the second in 625-line mode
    task automatic t_frames();
        logic [9:0] z[$] = '{10'h101, 10'h100, 10'h100, 10'h102, 10'h100, 10'h100};
        for (int f = 0; f < 3; f++) begin
            line625 = (f == 2);
            i_video_source.pending.push_back({10'h200, 3'b010});
            packet(8'hff, 8'h00, z, 10'h0, 10'h0, 10'h0, 1'b1,
                (f > 0) ? 14'h0700 : 14'h0000);
        end
        line625 = 1'b0;
        $display("test audio frames done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        rst_b = 1'b0;
        strictMode = 1'b0;
        line625 = 1'b0;
        haltOnError = 1'b0;
        clearCmd = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        check(inReady, 1'b1);
        t_preamble();
        t_words();
        t_blocks();
        t_audio();
        t_frames();
        stop_test();
    end
    initial begin
        #100us;
        n_mismatch++;
        stop_test();
    end
endmodule
